// File: logic/serial_break_idle_transmit.sv
// =============================================================
module serial_break_idle_transmit
  import serial_break_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rst,
  input  wire logic     ce,
  input  wire apb_req_t apb_req,
  output apb_rsp_t      apb_rsp,
  output logic          txd
);

  // =============================================================
  // declarations
  core_t       s_q;
  core_t       s_d;
  logic        hit_ctrl;
  logic        hit_baud;
  logic        hit_stat;
  logic        hit;
  logic        wr_en;
  logic        rd_setup;
  logic        bit_tick;
  logic        frame_end;
  logic [3:0]  frame_bits;
  logic [3:0]  last_bit;
  logic [31:0] rd_word;

  // start a new bit frame with the current divisor and word length
  function automatic core_t start_frame(core_t c, state_t nxt);
    core_t r;
    r          = c;
    r.mode     = nxt;
    r.baud_cnt = '0;
    r.bit_cnt  = '0;
    r.div_lat  = c.div;
    r.wl_lat   = c.wl;
    return r;
  endfunction : start_frame

  // =============================================================
  // apb decode
  assign hit_ctrl = (apb_req.paddr == CTRL_OFS);
  assign hit_baud = (apb_req.paddr == BAUD_OFS);
  assign hit_stat = (apb_req.paddr == STAT_OFS);
  assign hit      = hit_ctrl | hit_baud | hit_stat;
  assign wr_en    = apb_req.psel & apb_req.penable & apb_req.pwrite & ce;
  assign rd_setup = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;

  // zero wait states; frozen while clock enable is low
  assign apb_rsp.pready  = ce;
  assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~hit;
  assign apb_rsp.prdata  = s_q.prdata;
  assign txd             = s_q.txd;

  // =============================================================
  // bit timing
  assign frame_bits = s_q.wl_lat ? BITS_LONG : BITS_SHORT;
  assign last_bit   = (s_q.mode == MODE_GAP) ? (GAP_BITS - 4'h1) : (frame_bits - 4'h1);
  assign bit_tick   = (s_q.baud_cnt == s_q.div_lat);
  assign frame_end  = bit_tick && (s_q.bit_cnt == last_bit);

  // read word mux
  always_comb begin
    rd_word = '0;
    if (hit_ctrl) begin
      rd_word[BRK_BIT_POS] = s_q.brk_bit;
      rd_word[WL_POS]      = s_q.wl;
      rd_word[TX_EN_POS]   = s_q.tx_en;
    end else if (hit_baud) begin
      rd_word[15:0] = s_q.div;
    end else if (hit_stat) begin
      rd_word[STAT_STATE_LSB +: STAT_STATE_W] = s_q.mode;
      rd_word[STAT_IDLE_POS]                  = s_q.idle_pend;
      rd_word[STAT_BRK_POS]                   = s_q.brk_pend;
      rd_word[STAT_TXD_POS]                   = s_q.txd;
      rd_word[STAT_CNT_LSB +: STAT_CNT_W]     = s_q.brk_cnt;
    end
  end

  // =============================================================
  // next state
  always_comb begin
    s_d = s_q;
    // register writes
    if (wr_en && hit_ctrl && apb_req.pstrb[0]) begin
      s_d.brk_bit = apb_req.pwdata[BRK_BIT_POS];
      s_d.wl      = apb_req.pwdata[WL_POS];
      s_d.tx_en   = apb_req.pwdata[TX_EN_POS];
    end
    if (wr_en && hit_baud) begin
      for (int b = 0; b < DIV_BYTES; b++) begin
        if (apb_req.pstrb[b]) begin
          s_d.div[b*BYTE_W +: BYTE_W] = apb_req.pwdata[b*BYTE_W +: BYTE_W];
        end
      end
    end
    // read data is captured in the setup phase
    if (rd_setup) begin
      s_d.prdata = rd_word;
    end
    // baud and bit counters run inside any frame
    if (s_q.mode == MODE_IDLE || s_q.mode == MODE_BREAK || s_q.mode == MODE_GAP) begin
      if (bit_tick) begin
        s_d.baud_cnt = '0;
        s_d.bit_cnt  = s_q.bit_cnt + 4'h1;
      end else begin
        s_d.baud_cnt = s_q.baud_cnt + 16'h1;
      end
    end
    // line sequencer
    unique case (s_q.mode)
      MODE_OFF: begin
        if (s_q.tx_en) begin
          s_d.mode = MODE_READY;
        end
      end
      MODE_READY: begin
        if (!s_q.tx_en) begin
          s_d.mode = MODE_OFF;
        end else if (s_q.idle_pend) begin
          s_d           = start_frame(s_d, MODE_IDLE);
          s_d.idle_pend = 1'b0;
        end else if (s_q.brk_pend) begin
          s_d          = start_frame(s_d, MODE_BREAK);
          s_d.brk_pend = 1'b0;
          s_d.brk_cnt  = s_q.brk_cnt + 8'h1;
        end
      end
      MODE_IDLE: begin
        if (!s_q.tx_en) begin
          s_d.mode = MODE_OFF;
        end else if (frame_end) begin
          s_d.mode = MODE_READY;
        end
      end
      MODE_BREAK: begin
        if (!s_q.tx_en) begin
          s_d.mode = MODE_OFF;
        end else if (frame_end) begin
          s_d = start_frame(s_d, MODE_GAP);
        end
      end
      MODE_GAP: begin
        if (!s_q.tx_en) begin
          s_d.mode = MODE_OFF;
        end else if (frame_end) begin
          if (!s_q.idle_pend && s_q.brk_bit) begin
            s_d          = start_frame(s_d, MODE_BREAK);
            s_d.brk_pend = 1'b0;
            s_d.brk_cnt  = s_q.brk_cnt + 8'h1;
          end else begin
            s_d.mode = MODE_READY;
          end
        end
      end
    endcase
    // requests: a new edge wins over the clear above
    if (s_d.tx_en && !s_q.tx_en) begin
      s_d.idle_pend = 1'b1;
    end
    if (s_d.brk_bit && !s_q.brk_bit) begin
      s_d.brk_pend = 1'b1;
    end
    // line level follows the next state
    s_d.txd = (s_d.mode == MODE_BREAK) ? LINE_SPACE : LINE_IDLE;
    // clock enable freezes everything
    if (!ce) begin
      s_d = s_q;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q         <= '0;
      s_q.mode    <= MODE_OFF;
      s_q.div     <= BAUD_RST;
      s_q.div_lat <= BAUD_RST;
      s_q.txd     <= LINE_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // =============================================================
  // checks
  logic [19:0] brk_len;
  logic [19:0] exp_len;

  assign exp_len = 20'(20'(frame_bits) * (20'(s_q.div_lat) + 20'h1));

  // cycles spent in the current break
  always_ff @(posedge clk) begin
    if (rst) begin
      brk_len <= '0;
    end else if (ce) begin
      if (s_q.mode == MODE_BREAK) begin
        brk_len <= brk_len + 20'h1;
      end else begin
        brk_len <= '0;
      end
    end
  end

  // =============================================================
  // check sequences
  sequence s_break_ends;
    s_q.mode == MODE_BREAK && ce && s_q.tx_en && frame_end;
  endsequence

  sequence s_gap_repeat;
    s_q.mode == MODE_GAP && ce && s_q.tx_en && frame_end && s_q.brk_bit && !s_q.idle_pend;
  endsequence

  sequence s_gap_done;
    s_q.mode == MODE_GAP && ce && s_q.tx_en && frame_end && !s_q.brk_bit;
  endsequence

  sequence s_ctrl_write;
    wr_en && hit_ctrl && apb_req.pstrb[0];
  endsequence

  sequence s_break_launch;
    s_q.mode == MODE_READY && ce && s_q.tx_en && !s_q.idle_pend && s_q.brk_pend;
  endsequence

  sequence s_frame_abort;
    s_q.mode != MODE_OFF && s_q.mode != MODE_READY && ce && !s_q.tx_en;
  endsequence

  sequence s_idle_ends;
    s_q.mode == MODE_IDLE && ce && s_q.tx_en && frame_end;
  endsequence

  // frame timing and clock enable freeze
  a_break_len: assert property (@(posedge clk) disable iff (rst)
    s_break_ends |-> (brk_len + 20'h1 == exp_len))
    else $error("break length differs from nominal");

  a_break_launch: assert property (@(posedge clk) disable iff (rst)
    s_break_launch |=> (s_q.mode == MODE_BREAK && s_q.bit_cnt == 4'h0 && s_q.baud_cnt == 16'h0))
    else $error("queued break did not start");

  a_idle_ends: assert property (@(posedge clk) disable iff (rst)
    s_idle_ends |=> (s_q.mode == MODE_READY && txd == LINE_IDLE))
    else $error("idle frame did not end");

  a_ce_freeze: assert property (@(posedge clk) disable iff (rst)
    !ce |=> (s_q == $past(s_q)))
    else $error("state moved while clock enable low");

  // line level
  a_break_low: assert property (@(posedge clk) disable iff (rst)
    (s_q.mode == MODE_BREAK) |-> (txd == LINE_SPACE))
    else $error("line not low during break");

  a_idle_high: assert property (@(posedge clk) disable iff (rst)
    (s_q.mode == MODE_IDLE) |-> (txd == LINE_IDLE))
    else $error("line not high during idle frame");

  a_gap_high: assert property (@(posedge clk) disable iff (rst)
    (s_q.mode == MODE_GAP) |-> (txd == LINE_IDLE))
    else $error("line not high in gap after break");

  a_rest_high: assert property (@(posedge clk) disable iff (rst)
    (s_q.mode == MODE_OFF || s_q.mode == MODE_READY) |-> (txd == LINE_IDLE))
    else $error("line not high while no frame runs");

  // sequencing and requests
  a_line_return: assert property (@(posedge clk) disable iff (rst)
    s_break_ends |=> (txd == LINE_IDLE && s_q.mode == MODE_GAP))
    else $error("line not released after break");

  a_break_repeat: assert property (@(posedge clk) disable iff (rst)
    s_gap_repeat |=> (s_q.mode == MODE_BREAK && txd == LINE_SPACE && s_q.bit_cnt == 4'h0))
    else $error("held break bit did not repeat break");

  a_single_break: assert property (@(posedge clk) disable iff (rst)
    s_gap_done |=> (s_q.mode == MODE_READY && txd == LINE_IDLE))
    else $error("extra break after break bit cleared");

  a_abort_release: assert property (@(posedge clk) disable iff (rst)
    s_frame_abort |=> (s_q.mode == MODE_OFF && txd == LINE_IDLE))
    else $error("line not released after transmitter off");

  a_break_request: assert property (@(posedge clk) disable iff (rst)
    (s_ctrl_write and (apb_req.pwdata[BRK_BIT_POS] && !s_q.brk_bit)) |=> s_q.brk_pend)
    else $error("break request lost");

  a_idle_request: assert property (@(posedge clk) disable iff (rst)
    (s_ctrl_write and (apb_req.pwdata[TX_EN_POS] && !s_q.tx_en)) |=> s_q.idle_pend)
    else $error("idle request lost");

  a_idle_first: assert property (@(posedge clk) disable iff (rst)
    (s_q.mode == MODE_READY && ce && s_q.tx_en && s_q.idle_pend && s_q.brk_pend)
      |=> (s_q.mode == MODE_IDLE && txd == LINE_IDLE && s_q.brk_pend))
    else $error("break sent before queued idle");

endmodule : serial_break_idle_transmit

// File: logic/serial_break_pkg.sv
// =============================================================
// break and idle generator constants and types
package serial_break_pkg;

  // =============================================================
  // register map
  localparam int          ADDR_W    = 12;
  localparam int          DATA_W    = 32;
  localparam int          STRB_W    = 4;
  localparam int          BYTE_W    = 8;
  localparam int          DIV_BYTES = 2;
  localparam logic [11:0] CTRL_OFS  = 12'h000; // serial_control_two
  localparam logic [11:0] BAUD_OFS  = 12'h004; // serial_baud_rate_register
  localparam logic [11:0] STAT_OFS  = 12'h008; // status, read only

  // =============================================================
  // field positions
  localparam int BRK_BIT_POS    = 0; // send_break_bit
  localparam int WL_POS         = 1; // word-length select
  localparam int TX_EN_POS      = 2; // transmitter_enable_bit
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_STATE_W   = 3;
  localparam int STAT_IDLE_POS  = 4;
  localparam int STAT_BRK_POS   = 5;
  localparam int STAT_TXD_POS   = 6;
  localparam int STAT_CNT_LSB   = 8;
  localparam int STAT_CNT_W     = 8;

  // =============================================================
  // reset values and timing
  localparam logic [15:0] BAUD_RST   = 16'h0033; // cycles per bit minus one
  localparam logic [3:0]  BITS_SHORT = 4'ha;     // break length, word length 0
  localparam logic [3:0]  BITS_LONG  = 4'hb;     // break length, word length 1
  localparam logic [3:0]  GAP_BITS   = 4'h1;     // high bits after each break
  localparam logic        LINE_IDLE  = 1'b1;
  localparam logic        LINE_SPACE = 1'b0;

  // =============================================================
  // types
  typedef enum logic [2:0] {MODE_OFF, MODE_READY, MODE_IDLE, MODE_BREAK, MODE_GAP} state_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [STRB_W-1:0] pstrb;
  } apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
  } apb_rsp_t;

  typedef struct packed {
    state_t            mode;
    logic              brk_bit;
    logic              wl;
    logic              tx_en;
    logic [15:0]       div;
    logic [15:0]       div_lat;
    logic              wl_lat;
    logic [15:0]       baud_cnt;
    logic [3:0]        bit_cnt;
    logic              idle_pend;
    logic              brk_pend;
    logic              txd;
    logic [7:0]        brk_cnt;
    logic [DATA_W-1:0] prdata;
  } core_t;

endpackage : serial_break_pkg

// File: tb/line_rx_model.sv
// ====================
// remote receiver: measures each low stretch of the line
module line_rx_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        txd,
  output logic      [15:0] low_len,
  output logic      [7:0]  brk_seen
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [15:0] run_q;

  // count low cycles, log length when line goes high again
  always_ff @(posedge clk) begin
    if (rst) begin
      run_q    <= 16'h0000;
      low_len  <= 16'h0000;
      brk_seen <= 8'h00;
    end else if (txd === 1'b0) begin
      run_q <= run_q + 16'h0001;
    end else if (run_q != 16'h0000) begin
      low_len  <= run_q;
      brk_seen <= brk_seen + 8'h01;
      run_q    <= 16'h0000;
    end
  end
endmodule : line_rx_model

// File: tb/serial_break_idle_transmit_tb.sv
// ====================
// bench top
module serial_break_idle_transmit_tb
  import serial_break_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk;
  logic        rst;
  logic        ce;
  apb_req_t    apb_req;
  apb_rsp_t    apb_rsp;
  logic        txd;
  logic [15:0] low_len;
  logic [7:0]  brk_seen;
  logic [7:0]  b0;
  logic [15:0] div;
  logic [31:0] seed;
  logic [31:0] rd;
  logic [3:0]  strb;
  logic        err;
  int          num_errors;
  int          n_tests;

  serial_break_idle_transmit DUT (.clk(clk), .rst(rst), .ce(ce), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .txd(txd));
  line_rx_model rx (.clk(clk), .rst(rst), .txd(txd), .low_len(low_len), .brk_seen(brk_seen));

  // ====================
  // clock
  initial clk = 1'b0;
  always #50 clk = ~clk;

  // ====================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [31:0] brk_len(input logic wl, input logic [15:0] d);
    return 32'((wl ? 16'(BITS_LONG) : 16'(BITS_SHORT)) * (d + 16'h0001));
  endfunction : brk_len

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer, result in rd and err
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: strb};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    @(posedge clk);
    while (apb_rsp.pready !== 1'b1) @(posedge clk);
    rd  = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  task automatic wait_ready();
    for (int i = 0; i < 300; i++) begin
      apb(1'b0, STAT_OFS, 32'h0);
      if (rd[2:0] === 3'(MODE_READY)) break;
    end
    check(32'(rd[2:0]), 32'(MODE_READY));
  endtask : wait_ready

  task automatic wait_brk(input logic [7:0] n);
    for (int i = 0; i < 3000 && brk_seen !== n; i++) @(posedge clk);
    check(32'(brk_seen), 32'(n));
  endtask : wait_brk

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  // ====================
  // watchdog
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    end_of_test();
  end

  // ====================
  // main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    apb_req = '0;
    num_errors = 0;
    n_tests = 0;
    seed = 32'h351f;
    strb = 4'hf;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, BAUD_OFS, 32'h0);
    check(rd, {16'h0, BAUD_RST});
    apb(1'b0, CTRL_OFS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, STAT_OFS, 32'h0);
    check(rd, 32'h1 << STAT_TXD_POS);
    apb(1'b0, 12'hffc, 32'h0);
    check({31'h0, err}, 32'h1);
    @(posedge clk);
    ce <= 1'b0;
    @(posedge clk);
    check({31'h0, apb_rsp.pready}, 32'h0);
    ce <= 1'b1;
    $display("test reset done");
    // idle then single break for both word lengths
    for (int wl = 0; wl < 2; wl++) begin
      seed = lfsr(seed);
      div = {14'h0, seed[1:0]};
      apb(1'b1, BAUD_OFS, {16'h0, div});
      b0 = brk_seen;
      apb(1'b1, CTRL_OFS, 32'h0);
      apb(1'b1, CTRL_OFS, {29'h0, 1'b1, wl[0], 1'b0});
      apb(1'b1, CTRL_OFS, {29'h0, 1'b1, wl[0], 1'b1});
      apb(1'b1, CTRL_OFS, {29'h0, 1'b1, wl[0], 1'b0});
      apb(1'b0, STAT_OFS, 32'h0);
      check(32'(rd[2:0]), 32'(MODE_IDLE));
      check(32'(rd[STAT_BRK_POS]), 32'h1);
      wait_brk(b0 + 8'h01);
      check(32'(low_len), brk_len(wl[0], div));
      wait_ready();
      check(32'(brk_seen), 32'(b0 + 8'h01));
      check(32'(txd), 32'(LINE_IDLE));
      $display("test break wl=%0d div=%0d done", wl, div);
    end
    // break bit held: back to back breaks
    b0 = brk_seen;
    apb(1'b1, CTRL_OFS, 32'h7);
    wait_brk(b0 + 8'h02);
    check(32'(low_len), brk_len(1'b1, div));
    apb(1'b1, CTRL_OFS, 32'h6);
    wait_ready();
    check(32'(brk_seen - b0 >= 8'h02), 32'h1);
    check(32'(txd), 32'(LINE_IDLE));
    // transmitter off aborts a break
    apb(1'b1, CTRL_OFS, 32'h7);
    apb(1'b1, CTRL_OFS, 32'h0);
    @(posedge clk);
    #1 check(32'(txd), 32'(LINE_IDLE));
    apb(1'b0, STAT_OFS, 32'h0);
    check(32'(rd[2:0]), 32'(MODE_OFF));
    $display("test held break and abort done");
    // byte strobes: only enabled lanes are written
    seed = lfsr(seed);
    strb = 4'h2;
    apb(1'b1, BAUD_OFS, {16'h0, seed[7:0], 8'h00});
    strb = 4'he;
    apb(1'b1, CTRL_OFS, 32'h7);
    strb = 4'hf;
    apb(1'b0, BAUD_OFS, 32'h0);
    check(rd, {16'h0, seed[7:0], div[7:0]});
    apb(1'b0, CTRL_OFS, 32'h0);
    check(rd, 32'h0);
    $display("test byte strobes done");
    end_of_test();
  end
endmodule : serial_break_idle_transmit_tb
